// >>> core/pasf_tx.sv
// Chosen here: the Wishbone slave port.
`include "pasf_regs.svh"
`default_nettype none

module pasf_tx #(
    parameter int WORD_BITS = 32,
    parameter int TDM_SLOTS = 2,
    parameter int BUF_DEPTH = 2,
    parameter int INT_BCLK_HALF = `PASF_INT_BCLK_HALF
) (
    // system
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sample stream, upper word for the second pin
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [2*WORD_BITS-1:0] s_data,
    // bit clock and frame sync pins
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe_n,
    input wire logic fsync_i,
    output logic fsync_o,
    output logic fsync_oe_n,
    // data pins
    output logic [1:0] dout_o,
    output logic [1:0] dout_oe_n,
    output logic [1:0] dout_keep_o
);
    import pasf_pkg::*;

    localparam int PW = $clog2(WORD_BITS);
    localparam int SW = $clog2(TDM_SLOTS) + 1;
    localparam int DW = $clog2(INT_BCLK_HALF) + 1;
    localparam int FW = $clog2((TDM_SLOTS > 2 ? TDM_SLOTS : 2) * WORD_BITS) + 1;

    function automatic pasf_reg_t reg_dec(input logic [7:0] idx);
        if (idx == `PASF_LINE_CTRL_IDX)
            return REG_LINE;
        else if (idx == `PASF_SLOT_OFS_IDX)
            return REG_OFS;
        else if (idx == `PASF_PORT_CFG_IDX)
            return REG_CFG;
        else if (idx == `PASF_STATUS_IDX)
            return REG_STAT;
        else
            return REG_NONE;
    endfunction

    logic [7:0] ctrl_r;
    logic [4:0] ofs_r;
    logic [4:0] cfg_r;
    logic wb_req;
    pasf_reg_t wb_reg;
    logic [7:0] rd_val;
    logic tx_edge, fill_hiz, lsb_half, use_int_fs, use_int_bclk, pw2, pol, ctrl_mode, en;
    pasf_keep_t keep_mode;
    pasf_fmt_t fmt;
    logic active;

    assign tx_edge = ctrl_r[`PASF_EDGE_BIT];
    assign fill_hiz = ctrl_r[`PASF_FILL_BIT];
    assign lsb_half = ctrl_r[`PASF_LSB_BIT];
    assign keep_mode = pasf_keep_t'(ctrl_r[`PASF_KEEP_HI:`PASF_KEEP_LO]);
    assign use_int_fs = ctrl_r[`PASF_INT_FS_BIT];
    assign use_int_bclk = ctrl_r[`PASF_INT_BCLK_BIT];
    assign pw2 = ctrl_r[`PASF_PW_BIT];
    assign fmt = pasf_fmt_t'(cfg_r[`PASF_FMT_HI:`PASF_FMT_LO]);
    assign pol = cfg_r[`PASF_POL_BIT];
    assign ctrl_mode = cfg_r[`PASF_CTRL_BIT];
    assign en = cfg_r[`PASF_EN_BIT];
    assign active = en && (fmt != FMT_RSV);

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_reg = reg_dec(wb_adr_i[9:2]);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= `PASF_LINE_CTRL_RST;
            ofs_r <= `PASF_SLOT_OFS_RST;
            cfg_r <= `PASF_PORT_CFG_RST;
        end
        else if (wb_req && wb_we_i && wb_sel_i[0])
        begin
            if (wb_reg == REG_LINE)
                ctrl_r <= wb_dat_i[7:0];
            else if (wb_reg == REG_OFS)
                ofs_r <= wb_dat_i[`PASF_OFS_HI:`PASF_OFS_LO];
            else if (wb_reg == REG_CFG)
                cfg_r <= wb_dat_i[4:0];
        end
    end

    // synchronisers on the bit-clock and frame-sync pins, edge finding on the bit-clock pin
    logic [1:0] bclk_s_r;
    logic [1:0] fs_s_r;
    logic bclk_d_r;
    logic [DW-1:0] div_r;
    logic bclk_int_r;
    logic int_tick;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bclk_s_r <= 2'h0;
            fs_s_r <= 2'h0;
            bclk_d_r <= 1'b0;
        end
        else
        begin
            bclk_s_r <= {bclk_s_r[0], bclk_i};
            fs_s_r <= {fs_s_r[0], fsync_i};
            bclk_d_r <= bclk_s_r[1];
        end
    end

    // internal bit clock; only runs while driving as controller
    assign int_tick = active && ctrl_mode && (div_r == DW'(INT_BCLK_HALF - 1));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_r <= '0;
            bclk_int_r <= 1'b0;
        end
        else if (!(active && ctrl_mode))
        begin
            div_r <= '0;
        end
        else if (int_tick)
        begin
            div_r <= '0;
            bclk_int_r <= !bclk_int_r;
        end
        else
        begin
            div_r <= div_r + DW'(1);
        end
    end

    logic rise_ev, fall_ev, def_ev, opp_ev, launch_ev, half_ev, int_def;

    // bit clock that times the data
    assign rise_ev = (ctrl_mode && use_int_bclk) ? (int_tick && !bclk_int_r)
                                                 : (bclk_s_r[1] && !bclk_d_r);
    assign fall_ev = (ctrl_mode && use_int_bclk) ? (int_tick && bclk_int_r)
                                                 : (!bclk_s_r[1] && bclk_d_r);
    // polarity picks the default launch edge
    assign def_ev = pol ? rise_ev : fall_ev;
    assign opp_ev = pol ? fall_ev : rise_ev;
    assign launch_ev = tx_edge ? opp_ev : def_ev;
    assign half_ev = tx_edge ? def_ev : opp_ev;
    assign int_def = pol ? (int_tick && !bclk_int_r) : (int_tick && bclk_int_r);

    // internal frame sync, stepped on the internal default launch edge
    logic [FW-1:0] fcnt_r;
    logic [FW-1:0] fcnt_nxt;
    logic [FW-1:0] flen;
    logic fs_int_r;
    logic fs_int_nxt;

    assign flen = (fmt == FMT_TDM) ? FW'(TDM_SLOTS * WORD_BITS) : FW'(2 * WORD_BITS);
    assign fcnt_nxt = (fcnt_r >= flen - FW'(1)) ? '0 : fcnt_r + FW'(1);

    always_comb
    begin
        case (fmt)
            // pulse width one or two bit clocks
            FMT_TDM: fs_int_nxt = fcnt_nxt < (pw2 ? FW'(2) : FW'(1));
            FMT_I2S: fs_int_nxt = fcnt_nxt >= FW'(WORD_BITS);
            FMT_LJ: fs_int_nxt = fcnt_nxt < FW'(WORD_BITS);
            default: fs_int_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fcnt_r <= '0;
            fs_int_r <= 1'b0;
        end
        else if (int_def)
        begin
            fcnt_r <= fcnt_nxt;
            fs_int_r <= fs_int_nxt;
        end
    end

    assign bclk_o = bclk_int_r;
    assign fsync_o = fs_int_r;
    assign bclk_oe_n = !(active && ctrl_mode);
    assign fsync_oe_n = !(active && ctrl_mode);

    // frame start, sampled on the edge opposite the default launch
    logic fs_sel, fs_smp_r, start_ev;
    logic [5:0] delay;

    // frame sync that times the data
    assign fs_sel = (ctrl_mode && use_int_fs) ? fs_int_r : fs_s_r[1];
    assign start_ev = active && opp_ev &&
                      ((fmt == FMT_TDM) ? (fs_sel && !fs_smp_r) : (fs_sel != fs_smp_r));
    // offset added to the format's own MSB position
    assign delay = {1'b0, ofs_r} + {5'h00, fmt == FMT_I2S};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fs_smp_r <= 1'b0;
        else if (opp_ev)
            fs_smp_r <= fs_sel;
    end

    // sample buffer
    pasf_stream_if #(.W(2*WORD_BITS)) in_if ();
    pasf_stream_if #(.W(2*WORD_BITS)) out_if ();

    assign in_if.valid = s_valid;
    assign in_if.data = s_data;
    assign s_ready = in_if.ready;

    pasf_buf #(.W(2*WORD_BITS), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(clk),
        .nrst(nrst),
        .in_s(in_if.snk),
        .out_s(out_if.src)
    );

    // slot sequencer
    pasf_state_t state_r;
    logic [5:0] lead_r;
    logic [PW-1:0] bidx_r;
    logic [SW-1:0] slot_r;
    logic nxt_slot_r;
    logic have_r;
    logic [2*WORD_BITS-1:0] sh_r;
    logic begin_slot, emit_data, is_lsb;
    logic [1:0] bitv;

    always_comb
    begin
        begin_slot = 1'b0;
        if (launch_ev && !start_ev)
        begin
            case (state_r)
                ST_LEAD: begin_slot = (lead_r == 6'h00);
                ST_DATA: begin_slot = nxt_slot_r;
                default: begin_slot = 1'b0;
            endcase
        end
    end

    // a slot with no buffered word counts as unused cycles
    assign out_if.ready = begin_slot;
    assign emit_data = begin_slot ? out_if.valid
                                  : (launch_ev && !start_ev && state_r == ST_DATA && have_r);
    assign is_lsb = !begin_slot && (bidx_r == '0);
    // same bit position on both pins
    assign bitv = begin_slot ? {out_if.data[2*WORD_BITS-1], out_if.data[WORD_BITS-1]}
                             : {sh_r[WORD_BITS + int'(bidx_r)], sh_r[bidx_r]};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            lead_r <= 6'h00;
            bidx_r <= '0;
            slot_r <= '0;
            nxt_slot_r <= 1'b0;
            have_r <= 1'b0;
            sh_r <= '0;
        end
        else if (!active)
        begin
            state_r <= ST_IDLE;
            nxt_slot_r <= 1'b0;
        end
        else if (start_ev)
        begin
            state_r <= ST_LEAD;
            lead_r <= delay;
            slot_r <= '0;
            nxt_slot_r <= 1'b0;
        end
        else if (begin_slot)
        begin
            state_r <= ST_DATA;
            sh_r <= out_if.data;
            have_r <= out_if.valid;
            bidx_r <= PW'(WORD_BITS - 2);
            nxt_slot_r <= 1'b0;
        end
        else if (launch_ev)
        begin
            case (state_r)
                ST_LEAD: lead_r <= lead_r - 6'h01;
                ST_DATA:
                begin
                    if (bidx_r != '0)
                        bidx_r <= bidx_r - PW'(1);
                    else if (fmt == FMT_TDM && slot_r != SW'(TDM_SLOTS - 1))
                    begin
                        slot_r <= slot_r + SW'(1);
                        nxt_slot_r <= 1'b1;
                    end
                    else
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // pin drive; dout_r only moves while driving, so a keeper sees the last level
    logic [1:0] dout_r;
    logic drive_r;
    logic rel_pend_r;
    logic [1:0] kp_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dout_r <= 2'h0;
            drive_r <= 1'b0;
            rel_pend_r <= 1'b0;
            kp_r <= 2'h0;
        end
        else if (!active)
        begin
            drive_r <= 1'b0;
            rel_pend_r <= 1'b0;
            kp_r <= 2'h0;
        end
        else if (launch_ev)
        begin
            if (emit_data)
            begin
                dout_r <= bitv;
                drive_r <= 1'b1;
                rel_pend_r <= is_lsb && lsb_half;
            end
            else if (fill_hiz)
            begin
                drive_r <= 1'b0;
                rel_pend_r <= 1'b0;
            end
            else
            begin
                dout_r <= 2'h0;
                drive_r <= 1'b1;
                rel_pend_r <= 1'b0;
            end
            // keeper window counted in half cycles
            if (emit_data && is_lsb && keep_mode == KEEP_LSB1)
                kp_r <= 2'h2;
            else if (emit_data && is_lsb && keep_mode == KEEP_LSB15)
                kp_r <= 2'h3;
            else if (kp_r != 2'h0)
                kp_r <= kp_r - 2'h1;
        end
        else if (half_ev)
        begin
            if (rel_pend_r)
                drive_r <= 1'b0;
            rel_pend_r <= 1'b0;
            if (kp_r != 2'h0)
                kp_r <= kp_r - 2'h1;
        end
    end

    assign dout_o = dout_r;
    assign dout_oe_n = {2{!drive_r}};
    assign dout_keep_o = {2{active && (keep_mode == KEEP_ON || kp_r != 2'h0)}};

    always_comb
    begin
        if (wb_reg == REG_LINE)
            rd_val = ctrl_r;
        else if (wb_reg == REG_OFS)
            rd_val = {3'h0, ofs_r};
        else if (wb_reg == REG_CFG)
            rd_val = {3'h0, cfg_r};
        else if (wb_reg == REG_STAT)
            rd_val = {3'h0, fs_smp_r, dout_keep_o[0], out_if.valid, s_ready,
                      state_r != ST_IDLE};
        else
            rd_val = 8'h00;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wb_dat_o <= 32'h0;
        else if (wb_req)
            wb_dat_o <= {24'h0, rd_val};
    end

    // checks
    logic [15:0] hi_cnt_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hi_cnt_r <= 16'h0;
        else
            hi_cnt_r <= fs_int_r ? hi_cnt_r + 16'h1 : 16'h0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    ofs_read_a: assert property (
        wb_req && !wb_we_i && wb_reg == REG_OFS |=> wb_ack_o && wb_dat_o[7:5] == 3'h0)
        else $error("offset upper bits not zero");
    launch_edge_a: assert property (
        $changed(dout_o) |-> $past((tx_edge ^ pol) ? rise_ev : fall_ev))
        else $error("data changed off the launch edge");
    fill_zero_a: assert property (
        launch_ev && !emit_data && !fill_hiz && active |=> !dout_oe_n[0] && dout_o == 2'h0)
        else $error("unused cycle not driven low");
    fill_hiz_a: assert property (
        launch_ev && !emit_data && fill_hiz && active |=> dout_oe_n == 2'h3)
        else $error("unused cycle not released");
    lsb_release_a: assert property (
        launch_ev && emit_data && is_lsb && lsb_half && active
        ##1 (!launch_ev && !half_ev && active)[*1] ##0 (!half_ev)[*1]
        |-> !dout_oe_n[0])
        else $error("half LSB released too early");
    lsb_end_a: assert property (
        half_ev && rel_pend_r && active |=> dout_oe_n == 2'h3)
        else $error("half LSB not released");
    keep_len_a: assert property (
        launch_ev && emit_data && is_lsb && keep_mode == KEEP_LSB15 && active
        |=> kp_r == 2'h3 && dout_keep_o == 2'h3)
        else $error("keeper window not loaded");
    keeper_hold_a: assert property (
        dout_oe_n[0] && $past(dout_oe_n[0]) |-> $stable(dout_o))
        else $error("released pin level moved");
    pins_same_a: assert property (
        dout_oe_n[0] == dout_oe_n[1] && dout_keep_o[0] == dout_keep_o[1])
        else $error("data pins disagree on control");
    pulse_width_a: assert property (
        $fell(fs_int_r) && fmt == FMT_TDM && $stable(ctrl_r) && $stable(cfg_r)
        |-> hi_cnt_r == (pw2 ? 16'(4 * INT_BCLK_HALF) : 16'(2 * INT_BCLK_HALF)))
        else $error("frame pulse width wrong");
    lead_load_a: assert property (
        start_ev |=> state_r == ST_LEAD && lead_r == $past(delay))
        else $error("offset not loaded at frame start");

    slot_data_c: cover property (begin_slot && out_if.valid && fmt == FMT_TDM);
    underrun_c: cover property (begin_slot && !out_if.valid);
    half_lsb_c: cover property (half_ev && rel_pend_r);
    keep_long_c: cover property (kp_r == 2'h3);

endmodule

`default_nettype wire

// >>> core/pasf_regs.svh
`ifndef PASF_REGS_SVH
`define PASF_REGS_SVH

// register indices, byte address is four times the index
`define PASF_LINE_CTRL_IDX 8'h1B
`define PASF_SLOT_OFS_IDX 8'h1C
`define PASF_PORT_CFG_IDX 8'h20
`define PASF_STATUS_IDX 8'h21

`define PASF_LINE_CTRL_RST 8'h00
`define PASF_SLOT_OFS_RST 5'h00
`define PASF_PORT_CFG_RST 5'h00

// line control fields
`define PASF_EDGE_BIT 7
`define PASF_FILL_BIT 6
`define PASF_LSB_BIT 5
`define PASF_KEEP_HI 4
`define PASF_KEEP_LO 3
`define PASF_INT_FS_BIT 2
`define PASF_INT_BCLK_BIT 1
`define PASF_PW_BIT 0

// slot offset field
`define PASF_OFS_HI 4
`define PASF_OFS_LO 0

// port configuration fields
`define PASF_FMT_HI 1
`define PASF_FMT_LO 0
`define PASF_POL_BIT 2
`define PASF_CTRL_BIT 3
`define PASF_EN_BIT 4

// system clock cycles per half period of the internal bit clock
`define PASF_INT_BCLK_HALF 8

`endif

// >>> core/pasf_pkg.sv
`default_nettype none

package pasf_pkg;

    typedef enum logic [1:0] {
        FMT_TDM = 2'h0,
        FMT_I2S = 2'h1,
        FMT_LJ = 2'h2,
        FMT_RSV = 2'h3
    } pasf_fmt_t;

    typedef enum logic [1:0] {
        KEEP_OFF = 2'h0,
        KEEP_ON = 2'h1,
        KEEP_LSB1 = 2'h2,
        KEEP_LSB15 = 2'h3
    } pasf_keep_t;

    typedef enum {ST_IDLE, ST_LEAD, ST_DATA} pasf_state_t;

    typedef enum {REG_NONE, REG_LINE, REG_OFS, REG_CFG, REG_STAT} pasf_reg_t;

endpackage

`default_nettype wire

// >>> core/pasf_stream_if.sv
`default_nettype none

interface pasf_stream_if #(
    parameter int W = 64
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// >>> core/pasf_buf.sv
`default_nettype none

module pasf_buf #(
    parameter int W = 64,
    parameter int DEPTH = 2
) (
    // system
    input wire logic clk,
    input wire logic nrst,
    // streams
    pasf_stream_if.snk in_s,
    pasf_stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem_r[rd_r];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
            end
            if (pop)
            begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end

    buf_bound_a: assert property (@(posedge clk) disable iff (!nrst)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("buffer count beyond depth");

endmodule

`default_nettype wire

// >>> tb/pasf_host_model.sv
`default_nettype none

module pasf_host_model (
    // data pins seen from the host
    input wire logic [1:0] dout,
    input wire logic [1:0] dout_oe_n,
    input wire logic [1:0] keep,
    // link clock and frame sync driven by the host
    output logic bclk,
    output logic fsync
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] cap0;
    logic [63:0] cap1;
    logic [1:0] line;

    initial
    begin
        bclk = 1'h0;
        fsync = 1'h0;
    end

    // keeper holds level
    // a released line without keeper reads the opposite level, so stale data never matches
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            line[i] = (dout_oe_n[i] && !keep[i]) ? !dout[i] : dout[i];
    end

    task automatic grab;
        begin
            cap0 = {cap0[62:0], line[0]};
            cap1 = {cap1[62:0], line[1]};
        end
    endtask

    // clock stands at its idle level outside frames; 40 ns halves
    // inv flips the pin so an inverted-polarity port sees the same protocol
    task automatic frame(input logic fall, input logic inv);
        begin
            #1.3;
            bclk = !inv;
            #40;
            bclk = inv;
            fsync = 1'h1;
            #40;
            bclk = !inv;
            #40;
            bclk = inv;
            fsync = 1'h0;
            for (int i = 0; i < 64; i++)
            begin
                #40;
                bclk = !inv;
                if (!fall) grab();
                #40;
                bclk = inv;
                if (fall) grab();
            end
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/test_primary_asi_tx_formatter.sv
`default_nettype none

module test_primary_asi_tx_formatter;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic s_valid = 1'h0;
    logic s_ready;
    logic [31:0] s_data = 32'h0;
    logic bclk, fsync, bclk_o, bclk_oe_n, fsync_o, fsync_oe_n;
    logic [1:0] dout, oe_n, keep;
    logic [31:0] q;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    pasf_tx #(.WORD_BITS(16), .TDM_SLOTS(2), .BUF_DEPTH(2), .INT_BCLK_HALF(2)) DUT (
        .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .bclk_i(bclk),
        .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n), .fsync_i(fsync), .fsync_o(fsync_o),
        .fsync_oe_n(fsync_oe_n), .dout_o(dout), .dout_oe_n(oe_n), .dout_keep_o(keep)
    );

    pasf_host_model host (
        .dout(dout), .dout_oe_n(oe_n), .keep(keep), .bclk(bclk), .fsync(fsync)
    );

    always #2.5 clk = ~clk;

    task automatic finish_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, errors);
            if (errors == 0 && samples_checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
        begin
            samples_checked++;
            if (g !== e)
            begin
                errors++;
                $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] s, output logic [31:0] r);
        begin
            @(posedge clk);
            {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, 24'h0, d};
            do @(posedge clk); while (ack !== 1'h1);
            r = rdat;
            {cyc, stb} <= 2'h0;
            @(posedge clk);
        end
    endtask

    task automatic push(input logic [31:0] d);
        begin
            @(posedge clk);
            {s_valid, s_data} <= {1'h1, d};
            do @(posedge clk); while (s_ready !== 1'h1);
            s_valid <= 1'h0;
        end
    endtask

    task automatic t_regs;
        begin
            wb(1'h0, 10'h06C, 8'h00, 4'hF, q);
            cmp("line reset", 32'h0, q);
            wb(1'h0, 10'h070, 8'h00, 4'hF, q);
            cmp("offset reset", 32'h0, q);
            wb(1'h0, 10'h3FC, 8'h00, 4'hF, q);
            cmp("unmapped read", 32'h0, q);
            wb(1'h1, 10'h070, 8'h1F, 4'hF, q);
            wb(1'h0, 10'h070, 8'h00, 4'hF, q);
            cmp("offset upper bits", 32'h1F, q);
            wb(1'h1, 10'h06C, 8'h08, 4'hE, q);
            wb(1'h0, 10'h06C, 8'h00, 4'hF, q);
            cmp("masked write", 32'h0, q);
            // keeper output only follows the line setting while the port is enabled
            wb(1'h1, 10'h080, 8'h10, 4'hF, q);
            wb(1'h1, 10'h06C, 8'h08, 4'hF, q);
            cmp("keeper on", 2'h3, keep);
            wb(1'h1, 10'h06C, 8'h00, 4'hF, q);
            cmp("keeper off", 2'h0, keep);
        end
    endtask

    task automatic t_frame(input logic [4:0] ofs, input logic es, input logic fill,
        input logic [7:0] pc, input logic [5:0] lo);
        begin
            wb(1'h1, 10'h070, {3'h0, ofs}, 4'hF, q);
            wb(1'h1, 10'h06C, {es, fill, lo}, 4'hF, q);
            wb(1'h1, 10'h080, pc, 4'hF, q);
            push(32'h3CC3A55A);
            push(32'h0FF09669);
            host.frame(es, pc[2]);
            cmp("pin0 data", 32'hA55A9669, host.cap0[63-ofs -: 32]);
            cmp("pin1 data", 32'h3CC30FF0, host.cap1[63-ofs -: 32]);
            if (!fill) cmp("unused zero", 64'h0, host.cap0 << (32 + ofs));
            if (!fill) cmp("lead zero", 64'h0, host.cap0 >> (64 - ofs));
            cmp("oe after frame", {fill, fill}, oe_n);
        end
    endtask

    task automatic t_ctrl(input logic pw);
        int n;
        begin
            n = 0;
            wb(1'h1, 10'h06C, {7'h03, pw}, 4'hF, q);
            wb(1'h1, 10'h080, 8'h18, 4'hF, q);
            while (fsync_o !== 1'h0) @(posedge clk);
            while (fsync_o !== 1'h1) @(posedge clk);
            while (fsync_o === 1'h1)
            begin
                n++;
                @(posedge clk);
            end
            cmp("pulse clocks", 4 * (pw + 1), n);
            cmp("bclk driven", 1'h0, bclk_oe_n);
            cmp("fsync driven", 1'h0, fsync_oe_n);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        t_regs();
        t_frame(5'h00, 1'h0, 1'h0, 8'h10, 6'h00);
        t_frame(5'h1F, 1'h0, 1'h0, 8'h10, 6'h00);
        t_frame(5'h05, 1'h1, 1'h1, 8'h10, 6'h00);
        // inverted polarity, half-cycle LSB and the long keeper window
        t_frame(5'h03, 1'h0, 1'h1, 8'h14, 6'h38);
        t_ctrl(1'h0);
        t_ctrl(1'h1);
        finish_test();
    end
endmodule

`default_nettype wire
